// ### dv/ppc_pad_properties.sv
// Purpose: Port relations of the pad control block
// Assumes: Selects lag the register by one cycle
// Notes: Bound from tb_top
`timescale 1ns/10ps
module ppc_pad_props
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] rdata,
	input wire logic [7:0] port2_dir_out,
	input wire logic [7:0] port2_pullup_on,
	input wire logic slew_rate_enable,
	input wire logic port2_input_level_select,
	input wire logic mbi_input_level_select,
	input wire logic [7:0] port_pad_control
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire pw = wr_en && addr == 16'h0010;
	wire uw = wr_en && addr == 16'h0013;
	wire ur = rd_en && addr == 16'h0013;
	wire w0 = wdata[0];
	wire w6 = wdata[6];
	out_none_a:
	assert property ((port2_pullup_on & port2_dir_out) == 8'h00) else $error("pull-up on output");
	pu_write_a:
	assert property (uw |=> port2_pullup_on == ($past(wdata) & ~port2_dir_out)) else $error("pu");
	pu_read_a:
	assert property (ur |=> (rdata & ~$past(port2_dir_out)) == $past(port2_pullup_on))
		else $error("pu read");
	pu_hold_a:
	assert property ($stable(port2_dir_out) && !$past(wr_en) |-> $stable(port2_pullup_on))
		else $error("pu moved");
	slew_sel_a:
	assert property (pw ##1 !wr_en |=> slew_rate_enable == $past(w0, 2)) else $error("slew");
	level_sel_a:
	assert property (pw ##1 !wr_en |=> port2_input_level_select == $past(w6, 2)) else $error("lvl");
	pad_copy_a:
	assert property (pw ##1 !wr_en |=> port_pad_control == $past(wdata, 2)) else $error("copy");
	rd_idle_a:
	assert property (!rd_en |=> rdata == 8'h00) else $error("rdata idle");
endmodule

// ### dv/tb_top.sv
// Purpose: Bench for the pad control block
// Assumes: Slave never stalls, so fixed pacing
// Notes: Rows hold enable, direction, pull-up
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
	$display("[ERR] %0t %h %h", $time, a, b); end end
module tb_top;
	logic clk = 0, reset = 1, wr_en = 0, rd_en = 0;
	logic [15:0] addr = 0;
	logic [7:0] wdata = 0, rdata, port2_dir_out = 0, port2_pullup_on, port_pad_control;
	logic slew_rate_enable, port2_input_level_select, mbi_input_level_select;
	int num_errors = 0, checks = 0;
	logic [7:0] rows[4][3] = '{'{8'h01, 8'h00, 8'h01}, '{8'hA5, 8'h0F, 8'hA0},
		'{8'hFF, 8'hFF, 8'h00}, '{8'hC3, 8'h0F, 8'hC0}};
	always #10 clk = ~clk;
	ppc_pad_ctrl DUT
	(
		.clk(clk),
		.reset(reset),
		.addr(addr),
		.wdata(wdata),
		.wr_en(wr_en),
		.rd_en(rd_en),
		.rdata(rdata),
		.port2_dir_out(port2_dir_out),
		.port2_pullup_on(port2_pullup_on),
		.slew_rate_enable(slew_rate_enable),
		.port2_input_level_select(port2_input_level_select),
		.mbi_input_level_select(mbi_input_level_select),
		.port_pad_control(port_pad_control)
	);
	// The wr and rd tasks start on a fresh edge, so no strobe is driven twice
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1;
		@(posedge clk);
		wr_en <= 0;
	endtask
	task rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd_en <= 1;
		@(posedge clk);
		rd_en <= 0;
		#1 `CHK(rdata, e)
	endtask
	task end_sim;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge clk);
		reset <= 0;
		rd(16'h0010, 8'h00);
		rd(16'h0013, 8'h00);
		`CHK(port2_pullup_on, 8'h00)
		$display("reset test done");
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk);
			port2_dir_out <= rows[i][1];
			wr(16'h0013, rows[i][0]);
			#1 `CHK(port2_pullup_on, rows[i][2])
			rd(16'h0013, rows[i][0]);
		end
		$display("row test done");
		@(posedge clk);
		port2_dir_out <= 8'h00;
		#1 `CHK(port2_pullup_on, 8'hC3)
		// Status place is read-only
		wr(16'h0014, 8'hFF);
		rd(16'h0013, 8'hC3);
		rd(16'h0020, 8'h00);
		// Status must differ from the enables while some pins drive
		@(posedge clk);
		port2_dir_out <= 8'h81;
		rd(16'h0014, 8'h42);
		wr(16'h0010, 8'h41);
		@(posedge clk);
		#1 `CHK({mbi_input_level_select, port2_input_level_select, slew_rate_enable}, 3'h3)
		`CHK(port_pad_control, 8'h41)
		wr(16'h0010, 8'h80);
		@(posedge clk);
		#1 `CHK({mbi_input_level_select, port2_input_level_select, slew_rate_enable}, 3'h4)
		rd(16'h0010, 8'h80);
		$display("pad test done");
		@(posedge clk);
		reset <= 1;
		@(posedge clk);
		#1 `CHK({port_pad_control, port2_pullup_on}, 16'h0000)
		`CHK({mbi_input_level_select, port2_input_level_select, slew_rate_enable}, 3'h0)
		@(posedge clk);
		reset <= 0;
		rd(16'h0013, 8'h00);
		rd(16'h0010, 8'h00);
		$display("mid reset test done");
		end_sim;
	end
endmodule
bind ppc_pad_ctrl ppc_pad_props P
(
	.clk(clk),
	.reset(reset),
	.addr(addr),
	.wdata(wdata),
	.wr_en(wr_en),
	.rd_en(rd_en),
	.rdata(rdata),
	.port2_dir_out(port2_dir_out),
	.port2_pullup_on(port2_pullup_on),
	.slew_rate_enable(slew_rate_enable),
	.port2_input_level_select(port2_input_level_select),
	.mbi_input_level_select(mbi_input_level_select),
	.port_pad_control(port_pad_control)
);

// ### logic/ppc_pad_ctrl.sv
// Purpose: Port pad control and port 2 pull-up enable registers
// Assumes: Plain byte register port, strobes one cycle, never together
// Notes: Read data valid only in the cycle after the read strobe
//
// Notes on behaviour
// - Port 2 pull-ups enabled by software register
// - Enable bit n governs port 2 pin n
// - Pull-up applied only on enabled input pins
// - Output pins ignore enable, never pulled up
// - Enable bit 0 off, 1 on; bit0 lowest
// - Control bit 0 enables slew control, ports 0-3
// - Control bit 6: 0 reduced, 1 CMOS level
`timescale 1ns/10ps
`include "ppc_regs.svh"
module ppc_pad_ctrl
	import ppc_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [`PPC_ADDR_W-1:0] addr,
	input wire logic [`PPC_DATA_W-1:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [`PPC_DATA_W-1:0] rdata,
	input wire logic [`PPC_PINS-1:0] port2_dir_out,
	output logic [`PPC_PINS-1:0] port2_pullup_on,
	output logic slew_rate_enable,
	output logic port2_input_level_select,
	output logic mbi_input_level_select,
	output logic [`PPC_DATA_W-1:0] port_pad_control
);

	ppc_pad_if pad ();

	ppc_byte_t pad_control_r;
	ppc_byte_t pullup_enable_r;
	ppc_byte_t rdata_r;
	ppc_byte_t rdata_nxt;
	ppc_sel_t wr_sel;
	ppc_sel_t rd_sel;

	// Shared by the write and read paths
	function automatic ppc_sel_t decode(input logic [`PPC_ADDR_W-1:0] a);
		ppc_sel_t s;
		s = ppc_sel_none;
		case (a)
			`PPC_PAD_CONTROL_ADDR: s = ppc_sel_pad_control;
			`PPC_PULLUP_ENABLE_ADDR: s = ppc_sel_pullup_enable;
			`PPC_PULLUP_STATUS_ADDR: s = ppc_sel_pullup_status;
			default: s = ppc_sel_none;
		endcase
		return s;
	endfunction

	always_comb
	begin
		wr_sel = wr_en ? decode(addr) : ppc_sel_none;
		rd_sel = rd_en ? decode(addr) : ppc_sel_none;
	end

	// Pad control: all eight bits stored, upper meanings go to pad logic
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			pad_control_r <= `PPC_PAD_CONTROL_RESET;
		else if (wr_sel == ppc_sel_pad_control)
			pad_control_r <= wdata;
	end

	// Pull-up enables, one bit per pin, 1 enables
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			pullup_enable_r <= `PPC_PULLUP_ENABLE_RESET;
		else if (wr_sel == ppc_sel_pullup_enable)
			pullup_enable_r <= wdata;
	end

	// Slew and level selects registered from the stored control bits, one cycle later
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			slew_rate_enable <= `PPC_SELECT_RESET;
			port2_input_level_select <= `PPC_SELECT_RESET;
			mbi_input_level_select <= `PPC_SELECT_RESET;
			port_pad_control <= `PPC_PAD_CONTROL_RESET;
		end
		else
		begin
			slew_rate_enable <= pad_control_r[`PPC_SLEW_BIT];
			port2_input_level_select <= pad_control_r[`PPC_P2_LEVEL_BIT];
			mbi_input_level_select <= pad_control_r[`PPC_MBI_LEVEL_BIT];
			port_pad_control <= pad_control_r;
		end
	end

	// Gating kept combinational so a turn to output drops the pull-up at once
	always_comb
	begin
		pad.pullup_enable = pullup_enable_r;
		pad.dir_out = port2_dir_out;
		port2_pullup_on = pad.pullup_on;
	end

	ppc_pullup_gate u_gate
	(
		.pad(pad.gate)
	);

	// Unmapped reads answer zero; status shows the live pull-ups
	always_comb
	begin
		case (rd_sel)
			ppc_sel_pad_control: rdata_nxt = pad_control_r;
			ppc_sel_pullup_enable: rdata_nxt = pullup_enable_r;
			ppc_sel_pullup_status: rdata_nxt = pad.pullup_on;
			ppc_sel_none: rdata_nxt = `PPC_READ_IDLE;
			default: rdata_nxt = `PPC_READ_IDLE;
		endcase
	end

	// Idle value outside the answer cycle keeps the bus quiet
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			rdata_r <= `PPC_READ_IDLE;
		else
			rdata_r <= rdata_nxt;
	end

	assign rdata = rdata_r;

endmodule

// ### logic/ppc_pad_if.sv
// Purpose: Carries pull-up enables and direction to the gating logic
// Assumes: One clock domain, purely combinational path
// Notes: Direction bit high means the pin drives as an output
`timescale 1ns/10ps
interface ppc_pad_if;
	import ppc_pkg::*;

	ppc_byte_t pullup_enable;
	ppc_byte_t dir_out;
	ppc_byte_t pullup_on;

	modport regs
	(
		output pullup_enable,
		output dir_out,
		input pullup_on
	);

	modport gate
	(
		input pullup_enable,
		input dir_out,
		output pullup_on
	);
endinterface

// ### logic/ppc_pkg.sv
// Purpose: Shared types of the pad control block
// Assumes: Nothing beyond the register header
// Notes: Register select drives both write and read decode
package ppc_pkg;

	typedef logic [7:0] ppc_byte_t;

	typedef enum logic [1:0] {
		ppc_sel_none,
		ppc_sel_pad_control,
		ppc_sel_pullup_enable,
		ppc_sel_pullup_status
	} ppc_sel_t;

endpackage

// ### logic/ppc_pullup_gate.sv
// Purpose: Effective pull-up per port 2 pin
// Assumes: Direction bits are stable synchronous levels
// Notes: No storage, so the pad sees a direction change at once
`timescale 1ns/10ps
module ppc_pullup_gate
	import ppc_pkg::*;
(
	ppc_pad_if.gate pad
);

	// Pull-up only on an input pin whose enable is set
	always_comb
	begin
		pad.pullup_on = pad.pullup_enable & ~pad.dir_out;
	end

endmodule

// ### logic/ppc_regs.svh
// Purpose: Register map and field positions of the pad control block
// Assumes: Byte-wide registers on a 16-bit byte address
// Notes: Included by bare name
`ifndef PPC_REGS_SVH
`define PPC_REGS_SVH

`define PPC_ADDR_W 16
`define PPC_DATA_W 8
`define PPC_PINS 8

`define PPC_PAD_CONTROL_ADDR 16'h0010
`define PPC_PULLUP_ENABLE_ADDR 16'h0013
`define PPC_PULLUP_STATUS_ADDR 16'h0014

`define PPC_PAD_CONTROL_RESET 8'h00
`define PPC_PULLUP_ENABLE_RESET 8'h00
`define PPC_READ_IDLE 8'h00
`define PPC_SELECT_RESET 1'b0

`define PPC_SLEW_BIT 0
`define PPC_P2_LEVEL_BIT 6
`define PPC_MBI_LEVEL_BIT 7

`endif
